// ==== dcsa_defs.svh ====
// Constants for the disk controller status and address select block
`ifndef DCSA_DEFS_SVH
`define DCSA_DEFS_SVH
// Base word address with all switches off
`define DCSA_BASE_WORD 20'hF_FC00
// Word address weight of each switch
`define DCSA_W_SW4 20'h0_0008
`define DCSA_W_SW1 20'h0_0010
`define DCSA_W_SW2 20'h0_0020
`define DCSA_W_SW3 20'h0_0040
// Base byte address with all switches off, and the byte step per switch
`define DCSA_BASE_BYTE 16'hF800
`define DCSA_B_SW4 16'h0010
`define DCSA_B_SW1 16'h0020
`define DCSA_B_SW2 16'h0040
`define DCSA_B_SW3 16'h0080
// Decoded register window, words
`define DCSA_WIN_WORDS 20'h0_0008
// Register offsets on the internal port
`define DCSA_REG_STATUS 4'h0
`define DCSA_REG_CLEAR 4'h1
`define DCSA_REG_ENABLE 4'h2
`define DCSA_REG_IND 4'h3
`define DCSA_REG_BASE 4'h4
`define DCSA_REG_CTRL 4'h5
// Status bit positions
`define DCSA_EV_TIMEOUT 0
`define DCSA_EV_DIAG_FAIL 1
`define DCSA_EV_DIAG_PASS 2
`define DCSA_EV_CMD_DONE 3
`define DCSA_EV_W 4
// Control bit positions
`define DCSA_CTL_HOST_IRQ 0
`define DCSA_CTL_DIAG_START 1
`define DCSA_CTL_DIAG_PASS 2
`define DCSA_CTL_DIAG_FAIL 3
// Timing
`define DCSA_CMD_TIMEOUT_NS 1000000
`define DCSA_CLK_NS 8
`define DCSA_CLK_WATCH 8'h10
`endif

// ==== dcsa_host_model.sv ====
// Host side model that resets the interrupt after a delay
`timescale 1ns/10ps
module dcsa_host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_irq,
  input wire logic slow,
  output logic host_irq_reset
);
  logic [3:0] dly;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly <= 4'h0;
      host_irq_reset <= 1'b0;
    end else begin
      // Slow host leaves the line up long enough to be seen
      host_irq_reset <= host_irq && dly == (slow ? 4'h8 : 4'h1);
      dly <= (host_irq && !host_irq_reset) ? dly + 4'h1 : 4'h0;
    end
  end
endmodule // dcsa_host_model

// ==== dcsa_pkg.sv ====
// Types shared by the status and address select block
package dcsa_pkg;
  typedef struct packed {
    logic clock_ok;
    logic busy;
    logic irq;
    logic fault;
  } dcsa_led_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dcsa_req_t;
  typedef enum logic [1:0] {
    DCSA_IDLE = 2'b00,
    DCSA_EXEC = 2'b01,
    DCSA_DIAG = 2'b10,
    DCSA_TERM = 2'b11
  } dcsa_state_t;
endpackage

// ==== dcsa_sync.sv ====
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module dcsa_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule // dcsa_sync

// ==== dcsa_top.sv ====
// Status indicators, base address select and command timer of the
// disk controller
//
// Operation
// - All switches off decodes base word FFC00, byte address F800.
// - Switch weights add 08,10,20,40 words; byte address moves twice that.
// - Clock indicator lit while clock runs, dark when stalled or dead.
// - Busy lit from command start to its termination, dark when idle.
// - Interrupt indicator mirrors host interrupt line until host resets it.
// - Timer at maximum count sets fault; the terminate state it enters clears it a cycle later.
// - Fault set at self-test start, cleared on successful completion or by a command terminate sequence.
// - Strap tied to ground runs long self-test; open means normal.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "dcsa_defs.svh"
module dcsa_top
  import dcsa_pkg::*;
#(
  parameter int TIMEOUT_CYCLES =
    (`DCSA_CMD_TIMEOUT_NS + `DCSA_CLK_NS - 1) / `DCSA_CLK_NS,
  parameter int TW = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] slave_sw,
  input wire logic long_test_strap,
  input wire logic osc_tick,
  input wire logic mem_stall,
  input wire logic [19:0] host_word_addr,
  input wire logic cmd_start,
  input wire logic cmd_term,
  input wire logic host_irq_reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output dcsa_led_t led,
  output logic addr_hit,
  output logic [19:0] base_word,
  output logic [15:0] base_byte,
  output logic long_test,
  output logic host_irq,
  output logic irq
);
  // ==========================================================
  // Pin synchronisers
  logic [3:0] sw_s;
  logic strap_s;
  logic tick_s;
  logic stall_s;

  dcsa_sync #(.WIDTH(4), .INIT(4'h0)) u_sw_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(slave_sw),
    .q(sw_s)
  );

  // Open strap pulls high, so reset to the normal value
  dcsa_sync #(.WIDTH(3), .INIT(3'b100)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({long_test_strap, osc_tick, mem_stall}),
    .q({strap_s, tick_s, stall_s})
  );

  dcsa_req_t req;
  always_comb begin
    req.addr = reg_addr;
    req.wdata = reg_wdata;
    req.wr = reg_wr;
    req.rd = reg_rd;
  end

  // ==========================================================
  // Base address select
  logic [19:0] next_base_word;
  logic [15:0] next_base_byte;
  logic next_addr_hit;
  logic next_long_test;

  // Switches are not in binary order on the board
  always_comb begin
    next_base_word = `DCSA_BASE_WORD;
    next_base_byte = `DCSA_BASE_BYTE;
    if (sw_s[3]) begin
      next_base_word = next_base_word + `DCSA_W_SW4;
      next_base_byte = next_base_byte + `DCSA_B_SW4;
    end
    if (sw_s[0]) begin
      next_base_word = next_base_word + `DCSA_W_SW1;
      next_base_byte = next_base_byte + `DCSA_B_SW1;
    end
    if (sw_s[1]) begin
      next_base_word = next_base_word + `DCSA_W_SW2;
      next_base_byte = next_base_byte + `DCSA_B_SW2;
    end
    if (sw_s[2]) begin
      next_base_word = next_base_word + `DCSA_W_SW3;
      next_base_byte = next_base_byte + `DCSA_B_SW3;
    end
    next_addr_hit = (host_word_addr >= base_word) &&
      (host_word_addr < base_word + `DCSA_WIN_WORDS);
    next_long_test = !strap_s;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_word <= `DCSA_BASE_WORD;
      base_byte <= `DCSA_BASE_BYTE;
      addr_hit <= 1'b0;
      long_test <= 1'b0;
    end else begin
      base_word <= next_base_word;
      base_byte <= next_base_byte;
      addr_hit <= next_addr_hit;
      long_test <= next_long_test;
    end
  end

  // ==========================================================
  // Clock health watchdog
  logic tick_d;
  logic [7:0] tick_age;
  logic clock_ok;
  logic next_tick_d;
  logic [7:0] next_tick_age;
  logic next_clock_ok;

  // A missing oscillator edge or a memory stall darkens the lamp
  always_comb begin
    next_tick_d = tick_s;
    next_tick_age = tick_age;
    if (tick_s != tick_d) begin
      next_tick_age = 8'h00;
    end else if (tick_age != `DCSA_CLK_WATCH) begin
      next_tick_age = tick_age + 8'h01;
    end
    next_clock_ok = (tick_age != `DCSA_CLK_WATCH) && !stall_s;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_d <= 1'b0;
      tick_age <= 8'h00;
      clock_ok <= 1'b0;
    end else begin
      tick_d <= next_tick_d;
      tick_age <= next_tick_age;
      clock_ok <= next_clock_ok;
    end
  end

  // ==========================================================
  // Command sequencer, timer and fault
  dcsa_state_t state;
  dcsa_state_t next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic fault;
  logic next_fault;
  logic busy;
  logic next_busy;
  logic timeout_ev;
  logic diag_pass_ev;
  logic diag_fail_ev;
  logic done_ev;
  logic [15:0] ctrl;
  logic diag_go;

  assign diag_go = req.wr && req.addr == `DCSA_REG_CTRL &&
    req.wdata[`DCSA_CTL_DIAG_START];

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_fault = fault;
    timeout_ev = 1'b0;
    diag_pass_ev = 1'b0;
    diag_fail_ev = 1'b0;
    done_ev = 1'b0;
    case (state)
      DCSA_IDLE: begin
        next_timer = '0;
        if (diag_go) begin
          next_state = DCSA_DIAG;
          next_fault = 1'b1;
        end else if (cmd_start) begin
          next_state = DCSA_EXEC;
          next_timer = '0;
        end
      end
      DCSA_EXEC: begin
        if (cmd_term) begin
          next_state = DCSA_TERM;
        end else if (timer == TW'(TIMEOUT_CYCLES - 1)) begin
          next_fault = 1'b1;
          timeout_ev = 1'b1;
          next_state = DCSA_TERM;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      DCSA_DIAG: begin
        if (req.wr && req.addr == `DCSA_REG_CTRL &&
            req.wdata[`DCSA_CTL_DIAG_FAIL]) begin
          diag_fail_ev = 1'b1;
          next_state = DCSA_IDLE;
        end else if (req.wr && req.addr == `DCSA_REG_CTRL &&
                     req.wdata[`DCSA_CTL_DIAG_PASS]) begin
          next_fault = 1'b0;
          diag_pass_ev = 1'b1;
          next_state = DCSA_IDLE;
        end
      end
      DCSA_TERM: begin
        // Terminate state clears fault, whether entered on cmd_term or on a timeout
        next_fault = 1'b0;
        done_ev = 1'b1;
        next_state = DCSA_IDLE;
      end
      default: begin
        next_state = DCSA_IDLE;
      end
    endcase
    next_busy = (next_state == DCSA_EXEC) ||
      (next_state == DCSA_TERM);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= DCSA_IDLE;
      timer <= '0;
      fault <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      fault <= next_fault;
      busy <= next_busy;
    end
  end

  // ==========================================================
  // Host interrupt line and register file
  logic next_host_irq;
  logic [`DCSA_EV_W-1:0] status;
  logic [`DCSA_EV_W-1:0] next_status;
  logic [`DCSA_EV_W-1:0] enable;
  logic [`DCSA_EV_W-1:0] next_enable;
  logic [`DCSA_EV_W-1:0] events;
  logic [`DCSA_EV_W-1:0] clr;
  logic [15:0] next_ctrl;
  logic [15:0] next_rdata;
  logic next_irq;

  always_comb begin
    events = '0;
    events[`DCSA_EV_TIMEOUT] = timeout_ev;
    events[`DCSA_EV_DIAG_FAIL] = diag_fail_ev;
    events[`DCSA_EV_DIAG_PASS] = diag_pass_ev;
    events[`DCSA_EV_CMD_DONE] = done_ev;
    clr = '0;
    if (req.wr && req.addr == `DCSA_REG_CLEAR) begin
      clr = req.wdata[`DCSA_EV_W-1:0];
    end
    // Set beats clear so an event is never lost
    next_status = (status & ~clr) | events;
    next_enable = enable;
    next_ctrl = ctrl;
    if (req.wr && req.addr == `DCSA_REG_ENABLE) begin
      next_enable = req.wdata[`DCSA_EV_W-1:0];
    end else if (req.wr && req.addr == `DCSA_REG_CTRL) begin
      next_ctrl = req.wdata & 16'h0001;
    end
    // Raised line holds until the host resets it; raising wins
    next_host_irq = host_irq;
    if (next_ctrl[`DCSA_CTL_HOST_IRQ] && !ctrl[`DCSA_CTL_HOST_IRQ]) begin
      next_host_irq = 1'b1;
    end else if (host_irq_reset) begin
      next_host_irq = 1'b0;
    end
    next_rdata = 16'h0000;
    if (req.rd) begin
      if (req.addr == `DCSA_REG_STATUS) begin
        next_rdata = 16'(status);
      end else if (req.addr == `DCSA_REG_ENABLE) begin
        next_rdata = 16'(enable);
      end else if (req.addr == `DCSA_REG_IND) begin
        next_rdata = {12'h000, led};
      end else if (req.addr == `DCSA_REG_BASE) begin
        next_rdata = base_byte;
      end else if (req.addr == `DCSA_REG_CTRL) begin
        next_rdata = {ctrl[15:1], host_irq};
      end
    end
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_irq <= 1'b0;
      status <= '0;
      enable <= '0;
      ctrl <= 16'h0000;
      reg_rdata <= 16'h0000;
      irq <= 1'b0;
      led <= '0;
    end else begin
      host_irq <= next_host_irq;
      status <= next_status;
      enable <= next_enable;
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
      irq <= next_irq;
      led.clock_ok <= clock_ok;
      led.busy <= busy;
      led.irq <= next_host_irq;
      led.fault <= next_fault;
    end
  end
endmodule // dcsa_top

// ==== dcsa_top_assertions.sv ====
// Checker for the status and address select block
`timescale 1ns/10ps
`include "dcsa_defs.svh"
module dcsa_top_chk
  import dcsa_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 125000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] slave_sw,
  input wire logic long_test_strap,
  input wire logic cmd_start,
  input wire logic cmd_term,
  input wire logic host_irq_reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire dcsa_led_t led,
  input wire logic [19:0] base_word,
  input wire logic [15:0] base_byte,
  input wire logic long_test,
  input wire logic host_irq
);
  logic [2:0] up;
  int run;
  wire logic ctl_wr = reg_wr && reg_addr == `DCSA_REG_CTRL;
  wire logic [19:0] exp_w =
    20'hf_fc00 + {13'h0, slave_sw[2:0], slave_sw[3], 3'h0};
  // ========================================
  // Helpers
  // Guard: outputs registered from synchronised pins lag reset release by three edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up <= 3'h0;
      run <= 0;
    end else begin
      up <= (up == 3'h7) ? up : up + 3'h1;
      if (cmd_term || run == TIMEOUT_CYCLES) begin
        run <= 0;
      end else if (run != 0 || cmd_start) begin
        run <= run + 1;
      end
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_bw;
    up > 3'h4 && $stable(slave_sw)[*4] |-> base_word == exp_w;
  endproperty
  a_bw: assert property (p_bw) else $error("base word");
  property p_bb;
    base_byte == {base_word[14:0], 1'b0};
  endproperty
  a_bb: assert property (p_bb) else $error("base byte");
  property p_lt;
    up > 3'h4 && $stable(long_test_strap)[*4] |->
      long_test == !long_test_strap;
  endproperty
  a_lt: assert property (p_lt) else $error("long test");
  property p_irq_hold;
    $fell(host_irq) |-> $past(host_irq_reset) || $past(host_irq_reset, 2);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq drop");
  property p_busy_on;
    cmd_start && !led.busy |-> ##[1:3] led.busy;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy on");
  property p_busy_off;
    cmd_term && led.busy |-> ##[1:5] !led.busy;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy off");
  property p_to;
    run == TIMEOUT_CYCLES |-> ##[0:3] led.fault;
  endproperty
  a_to: assert property (p_to) else $error("timeout fault");
  property p_dg;
    ctl_wr && reg_wdata[1] && !led.busy |-> ##[1:3] led.fault;
  endproperty
  a_dg: assert property (p_dg) else $error("diag fault");
  cover property (cmd_start ##[1:3] led.busy);
  cover property ($rose(led.fault));
  cover property ($fell(host_irq));
endmodule // dcsa_top_chk

// ==== dcsa_top_bench.sv ====
// Self-checking bench of the status and address select block
`timescale 1ns/10ps
`include "dcsa_defs.svh"
module dcsa_top_bench;
  import dcsa_pkg::*;
  localparam int TO = 20;
  logic [19:0] host_word_addr, base_word, ew;
  logic [15:0] reg_wdata, reg_rdata, base_byte;
  logic [3:0] slave_sw, reg_addr, ledv;
  logic clk, reset_n, long_test_strap, osc_tick, mem_stall, cmd_start;
  logic cmd_term, host_irq_reset, reg_wr, reg_rd, addr_hit, long_test;
  logic host_irq, irq, slow, osc_en, rd_q;
  logic [31:0] lf;
  logic [15:0] expq[$];
  dcsa_led_t led;
  int fail_count, tests_run;
  assign ledv = led;
  dcsa_top #(.TIMEOUT_CYCLES(TO)) dut (.*);
  dcsa_host_model host (.clk(clk), .reset_n(reset_n), .host_irq(host_irq),
    .slow(slow), .host_irq_reset(host_irq_reset));
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait on one indicator; running out ends the run
  task automatic wled(int i, logic v, int n);
    tests_run++;
    repeat (n) begin
      @(posedge clk);
      if (ledv[i] === v) return;
    end
    fail_count++;
    $display("MISMATCH led%0d exp %b seen %b", i, v, ledv[i]);
    end_of_test();
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic cmd(logic t);
    @(posedge clk);
    if (t) cmd_term <= 1'b1;
    else cmd_start <= 1'b1;
    @(posedge clk);
    cmd_start <= 1'b0;
    cmd_term <= 1'b0;
  endtask
  // ========================================
  // Clock, oscillator, read monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (osc_en) osc_tick <= ~osc_tick;
    if (rd_q) chk("rdata", {4'h0, reg_rdata}, {4'h0, expq.pop_front()});
    rd_q <= reg_rd;
  end
  initial begin
    cyc(5000);
    fail_count++;
    end_of_test();
  end
  // ========================================
  // Main sequence
  initial begin
    {reset_n, slave_sw, osc_tick, mem_stall, cmd_start, cmd_term} = '0;
    {host_word_addr, reg_addr, reg_wdata, reg_wr, reg_rd, slow} = '0;
    {long_test_strap, osc_en, rd_q, lf} = {1'b1, 1'b1, 1'b0, 32'h0000_2aea};
    cyc(20);
    chk("bw", base_word, 20'hf_fc00);
    chk("bb", {4'h0, base_byte}, 20'h0_f800);
    reset_n <= 1'b1;
    for (int s = 0; s < 16; s++) begin
      lf = nxt(lf);
      ew = 20'hf_fc00 + {13'h0, s[2:0], s[3], 3'h0};
      slave_sw <= s[3:0];
      cyc(5);
      chk("bw", base_word, ew);
      chk("bb", {4'h0, base_byte}, {4'h0, ew[14:0], 1'b0});
      host_word_addr <= ew + {17'h0, lf[2:0]};
      cyc(2);
      chk("hit", 20'(addr_hit), 20'h0_0001);
      host_word_addr <= ew + 20'h0_0008 + {16'h0, lf[6:3]};
      rd(`DCSA_REG_BASE, {ew[14:0], 1'b0});
      chk("miss", 20'(addr_hit), 20'h0_0000);
    end
    for (int v = 0; v < 2; v++) begin
      long_test_strap <= v[0];
      cyc(5);
      chk("lt", 20'(long_test), 20'(!v[0]));
    end
    wled(3, 1'b1, 40);
    rd(`DCSA_REG_IND, 16'h0008);
    mem_stall <= 1'b1;
    wled(3, 1'b0, 8);
    mem_stall <= 1'b0;
    wled(3, 1'b1, 40);
    osc_en <= 1'b0;
    wled(3, 1'b0, 30);
    osc_en <= 1'b1;
    wr(`DCSA_REG_CLEAR, 16'h000f);
    wr(`DCSA_REG_ENABLE, 16'h0008);
    cmd(0);
    wled(2, 1'b1, 4);
    cyc(8);
    chk("busy", 20'(led.busy), 20'h0_0001);
    cmd(1);
    wled(2, 1'b0, 6);
    cyc(2);
    chk("irq", 20'(irq), 20'h0_0001);
    wr(`DCSA_REG_ENABLE, 16'h0000);
    cyc(2);
    chk("irq", 20'(irq), 20'h0_0000);
    wr(`DCSA_REG_STATUS, 16'h0000);
    rd(`DCSA_REG_STATUS, 16'h0008);
    rd(4'hf, 16'h0000);
    wr(`DCSA_REG_CLEAR, 16'h000f);
    cmd(0);
    wled(0, 1'b1, TO + 6);
    wled(0, 1'b0, 4);
    wled(2, 1'b0, 6);
    wr(`DCSA_REG_CLEAR, 16'h0008);
    rd(`DCSA_REG_STATUS, 16'h0001);
    wr(`DCSA_REG_CLEAR, 16'h000f);
    // Two commands just under the limit; a timer that keeps running trips
    for (int i = 0; i < 2; i++) begin
      cmd(0);
      cyc(TO - 6);
      cmd(1);
      cyc(4);
    end
    rd(`DCSA_REG_STATUS, 16'h0008);
    chk("fault", 20'(led.fault), 20'h0_0000);
    wr(`DCSA_REG_CLEAR, 16'h000f);
    wr(`DCSA_REG_CTRL, 16'h0002);
    wled(0, 1'b1, 4);
    wr(`DCSA_REG_CTRL, 16'h0008);
    cyc(6);
    chk("fault", 20'(led.fault), 20'h0_0001);
    // Failed test went back to idle; a passing rerun darkens fault
    wr(`DCSA_REG_CTRL, 16'h0002);
    wr(`DCSA_REG_CTRL, 16'h0004);
    wled(0, 1'b0, 4);
    rd(`DCSA_REG_STATUS, 16'h0006);
    for (int m = 0; m < 2; m++) begin
      slow <= m[0];
      wr(`DCSA_REG_CTRL, 16'h0000);
      wr(`DCSA_REG_CTRL, 16'h0001);
      wled(1, 1'b1, 3);
      cyc(3);
      chk("hirq", 20'(host_irq), 20'(m[0]));
      wled(1, 1'b0, 16);
    end
    end_of_test();
  end
endmodule // dcsa_top_bench
bind dcsa_top dcsa_top_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (.*);
